// [bench/host_model.sv]
// host side model: drives one register request at a time on the falling edge.
// assumes the bench calls its tasks from a single process.
`timescale 1ns/1ns
`default_nettype none
module host_model
	import mirror_ctrl_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic               [15:0] rdata_i,
	input  wire logic                      hit_i,
	output var  mirror_ctrl_pkg::reg_req_t req_o
);
	initial req_o = '0;
	// leading wait keeps back-to-back calls from driving the strobe twice at one edge
	task automatic bus_write(input logic [5:0] a, input logic [15:0] d);
		@(negedge clk_i);
		// reserved top bit of register two is cleared before the word goes out
		req_o = '{rd: 1'b0, wr: 1'b1, addr: a,
			wdata: (a == DRIVER_GLASS_ADDR) ? (d & DRIVER_GLASS_WMASK) : d};
		@(negedge clk_i);
		req_o = '0;
	endtask : bus_write
	// answer is sampled at the falling edge after the taking edge
	task automatic bus_read(input logic [5:0] a, output logic [15:0] d, output logic h);
		@(negedge clk_i);
		req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(negedge clk_i);
		d = rdata_i;
		h = hit_i;
		req_o = '0;
	endtask : bus_read
endmodule : host_model
`default_nettype wire

// [bench/mirror_ctrl_checker.sv]
// checker: port timing of the mirror driver control register bank.
// assumes one clock domain; bound onto the top module from the bench.
`timescale 1ns/1ns
`default_nettype none
module mirror_ctrl_checker
	import mirror_ctrl_pkg::*;
(
	input wire logic                        ref_clk_i,
	input wire logic                        arst_n_i,
	input wire mirror_ctrl_pkg::reg_req_t   reg_req_i,
	input wire logic                 [15:0] reg_rdata_o,
	input wire logic                        reg_hit_o,
	input wire mirror_ctrl_pkg::drive_out_t drive_o,
	input wire logic                        rx_data_i,
	input wire logic                        rx_pin_o,
	input wire logic                        irq_request_i,
	input wire logic                        standby_active_i,
	input wire logic                        cfg_kick_toggle_i,
	input wire logic                        supply_reset_level_sel_o,
	input wire logic                 [12:0] supply_reset_threshold_mv_o,
	input wire logic                        enter_standby_o,
	input wire logic                        standby_kind_select_o,
	input wire logic                        watchdog_disable_o,
	input wire logic                        watchdog_service_o
);
	logic go_w;
	// enter-standby write as seen on the request bus
	assign go_w = reg_req_i.wr && reg_req_i.addr == BRIDGE_MODE_ADDR
		&& reg_req_i.wdata[ENTER_STANDBY_BIT];
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	sequence s_go;
		go_w;
	endsequence
	sequence s_rd1;
		reg_req_i.rd && reg_req_i.addr == BRIDGE_MODE_ADDR;
	endsequence
	AST_READ_TOP_ZERO: assert property (reg_req_i.rd && reg_req_i.addr == DRIVER_GLASS_ADDR
		|=> reg_hit_o && !reg_rdata_o[15]) else $error("top bit of register two read back set");
	AST_ONESHOT_READ: assert property (s_rd1 |=> reg_hit_o && reg_rdata_o[2:1] == 2'h0)
		else $error("one-shot bits read back set");
	AST_STANDBY_GO: assert property (s_go
		|=> enter_standby_o && standby_kind_select_o == $past(reg_req_i.wdata[STANDBY_KIND_BIT]))
		else $error("standby request not taken");
	AST_STANDBY_QUIET: assert property (!go_w |=> !enter_standby_o)
		else $error("standby pulse without request");
	AST_BRIDGE_EXCL: assert property ((drive_o.bridge_high & drive_o.bridge_low) == 5'h00)
		else $error("both drivers of a half bridge on");
	AST_RESET_LEVEL: assert property (supply_reset_threshold_mv_o ==
		(supply_reset_level_sel_o ? RESET_THR_LOW_MV : RESET_THR_HIGH_MV))
		else $error("reset threshold does not match level select");
	AST_SEVEN_HELD: assert property (drive_o.glass_control_enable |-> drive_o.high_side_seven)
		else $error("seventh output off while glass control on");
	AST_CFG_KICK: assert property (cfg_kick_toggle_i |=> watchdog_service_o)
		else $error("configuration kick not serviced");
	AST_RX_PLAIN: assert property (!irq_request_i |=> rx_pin_o == $past(rx_data_i))
		else $error("receive pin does not follow receive data");
	AST_WD_AWAKE: assert property (!standby_active_i |=> !watchdog_disable_o)
		else $error("watchdog disabled outside standby");
endmodule : mirror_ctrl_checker
`default_nettype wire

// [bench/tb_mirror_driver_control_regs.sv]
// bench for the control register bank: host model requests, level inputs at falling edges.
// assumes the design package and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_mirror_driver_control_regs;
	import mirror_ctrl_pkg::*;
	logic clk, rst_n, pa, pb, pc, rxd, irq, sby, below, ktog, hit, rxp, lvl, go, kind, wdd, svc;
	logic [15:0] rdata;
	logic [12:0] thr;
	reg_req_t    req;
	drive_cfg_t  cfg;
	drive_out_t  dout;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cycles = 0;
	mirror_driver_control_regs mirror_driver_control_regs_i (.ref_clk_i(clk), .arst_n_i(rst_n),
		.reg_req_i(req), .reg_rdata_o(rdata), .reg_hit_o(hit), .drive_cfg_i(cfg),
		.pwm_input_a_i(pa), .pwm_input_b_i(pb), .pwm_input_c_i(pc), .rx_data_i(rxd),
		.irq_request_i(irq), .standby_active_i(sby), .supply_current_below_i(below),
		.cfg_kick_toggle_i(ktog), .drive_o(dout), .rx_pin_o(rxp), .supply_reset_level_sel_o(lvl),
		.supply_reset_threshold_mv_o(thr), .enter_standby_o(go), .standby_kind_select_o(kind),
		.watchdog_disable_o(wdd), .watchdog_service_o(svc));
	host_model host_model_i (.clk_i(clk), .rdata_i(rdata), .hit_i(hit), .req_o(req));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask : chkb
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		host_model_i.bus_write(a, d);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		logic [15:0] v;
		logic        h;
		host_model_i.bus_read(a, v, h);
		chk(v, exp);
		chkb(h, 1'b1);
	endtask : rd
	task automatic step;
		@(negedge clk);
	endtask : step
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard: the sequence needs well under a few hundred cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial
	begin
		logic [15:0] v;
		logic        h;
		{rst_n, pa, pb, pc, irq, sby, below, ktog} = 8'h00;
		rxd = 1'b1;
		cfg = '0;
		repeat (20) step();
		rst_n = 1'b1;
		step();
		rd(BRIDGE_MODE_ADDR, BRIDGE_MODE_RESET);
		rd(DRIVER_GLASS_ADDR, DRIVER_GLASS_RESET);
		chkb(rxp, 1'b1);
		// half bridges: bridge five both set, four and three high side
		wr(BRIDGE_MODE_ADDR, 16'hE920);
		chkb(hit, 1'b1);
		chk(16'(dout.bridge_high), 16'h000C);
		chk(16'(dout.bridge_low), 16'h0002);
		chk(16'(dout.bridge_high_z), 16'h0011);
		cfg.bridge_pwm_en = 5'h04;
		step();
		chk(16'(dout.bridge_high), 16'h0008);
		pa = 1'b1;
		step();
		chk(16'(dout.bridge_high), 16'h000C);
		rd(BRIDGE_MODE_ADDR, 16'hE920);
		// reset level and shared receive pin
		irq = 1'b1;
		wr(BRIDGE_MODE_ADDR, 16'h0030);
		chkb(lvl, 1'b1);
		chk(16'(thr), 16'(RESET_THR_LOW_MV));
		chkb(rxp, 1'b0);
		wr(BRIDGE_MODE_ADDR, 16'h0000);
		chkb(rxp, 1'b1);
		chk(16'(thr), 16'(RESET_THR_HIGH_MV));
		// standby request with a kick toggle in the same word
		wr(BRIDGE_MODE_ADDR, 16'h0027);
		chkb(go, 1'b1);
		chkb(kind, STANDBY_REGULATOR);
		chkb(svc, 1'b1);
		step();
		chkb(go, 1'b0);
		chkb(svc, 1'b0);
		rd(BRIDGE_MODE_ADDR, 16'h0021);
		sby = 1'b1;
		below = 1'b1;
		step();
		chkb(wdd, 1'b1);
		below = 1'b0;
		step();
		chkb(wdd, 1'b0);
		wr(BRIDGE_MODE_ADDR, 16'h0029);
		chkb(svc, 1'b0);
		step();
		chkb(wdd, 1'b1);
		wr(BRIDGE_MODE_ADDR, 16'h0022);
		chkb(kind, STANDBY_BATTERY);
		chkb(svc, 1'b1);
		wr(BRIDGE_MODE_ADDR, 16'h0025);
		chkb(kind, STANDBY_BATTERY);
		sby = 1'b0;
		ktog = 1'b1;
		step();
		ktog = 1'b0;
		chkb(svc, 1'b1);
		// register two: every field on except the eighth output, then gated by pwm
		wr(DRIVER_GLASS_ADDR, 16'hFFFF);
		chk(16'({dout.glass_fast_discharge_low, dout.glass_volt_low_side, dout.high_side_nine,
			dout.high_side_eight_hi_cur, dout.high_side_eight_lo_cur, dout.high_side_seven,
			dout.high_side_six, dout.glass_negative_discharge, dout.glass_control_enable}),
			16'h01CF);
		chk(16'(dout.glass_ref_mv), 16'h04B0);
		chk(16'(dout.glass_ref_code), 16'h003F);
		cfg.glass_full_scale_sel = 1'b1;
		step();
		chk(16'(dout.glass_ref_mv), 16'h05DC);
		rd(DRIVER_GLASS_ADDR, 16'h7FFF);
		{cfg.glass_volt_pwm_gate, cfg.high_side_nine_pwm_gate, cfg.high_side_seven_pwm_gate} = 3'h7;
		{cfg.high_side_six_pwm_gate, cfg.high_side_eight_pwm_gate, pa} = 3'h6;
		step();
		chk(16'({dout.glass_volt_low_side, dout.high_side_nine, dout.high_side_seven,
			dout.high_side_six}), 16'h0002);
		wr(DRIVER_GLASS_ADDR, 16'h0200);
		chkb(dout.high_side_seven, 1'b0);
		chk(16'(dout.glass_ref_mv), 16'h0000);
		pa = 1'b1;
		pc = 1'b1;
		step();
		chkb(dout.high_side_seven, 1'b1);
		// eighth output field, every code
		for (int i = 0; i < 4; i++)
		begin
			wr(DRIVER_GLASS_ADDR, 16'(i) << 10);
			chk(16'({dout.high_side_eight_hi_cur, dout.high_side_eight_lo_cur}),
				(i == 1 || i == 2) ? 16'(i) : 16'h0000);
		end
		wr(6'h03, 16'h0001);
		chkb(hit, 1'b0);
		host_model_i.bus_read(6'h03, v, h);
		chkb(h, 1'b0);
		chk(v, 16'h0000);
		report_and_stop();
	end
endmodule : tb_mirror_driver_control_regs
bind mirror_driver_control_regs mirror_ctrl_checker mirror_ctrl_checker_i (
	.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
	.reg_hit_o(reg_hit_o), .drive_o(drive_o), .rx_data_i(rx_data_i), .rx_pin_o(rx_pin_o),
	.irq_request_i(irq_request_i), .standby_active_i(standby_active_i),
	.cfg_kick_toggle_i(cfg_kick_toggle_i), .supply_reset_level_sel_o(supply_reset_level_sel_o),
	.supply_reset_threshold_mv_o(supply_reset_threshold_mv_o), .enter_standby_o(enter_standby_o),
	.standby_kind_select_o(standby_kind_select_o), .watchdog_disable_o(watchdog_disable_o),
	.watchdog_service_o(watchdog_service_o));
`default_nettype wire

// [include/mirror_ctrl_pkg.sv]
// package for the mirror driver control register bank: offsets, field positions,
// reset values, scaling constants and the carrier structs shared by the design files.
// assumes the serial frame layer outside has already decoded address and data.
`default_nettype none

package mirror_ctrl_pkg;

	// register addresses as seen on the serial frame
	localparam logic [5:0]  ADDR_WIDTH_DUMMY   = 6'h00;
	localparam logic [5:0]  BRIDGE_MODE_ADDR   = 6'h01;
	localparam logic [5:0]  DRIVER_GLASS_ADDR  = 6'h02;

	// reset values and write masks
	localparam logic [15:0] BRIDGE_MODE_RESET  = 16'h0020;
	localparam logic [15:0] DRIVER_GLASS_RESET = 16'h0000;
	localparam logic [15:0] BRIDGE_MODE_WMASK  = 16'hFFF9; // one-shot bits never stored
	localparam logic [15:0] DRIVER_GLASS_WMASK = 16'h7FFF; // top bit reserved

	// bridge_and_mode_control fields
	localparam int BRIDGE_FIELD_LSB   = 6;  // pairs high/low from bit 6 upward
	localparam int IRQ_RX_EN_BIT      = 5;
	localparam int RESET_LEVEL_BIT    = 4;
	localparam int CUR_CMP_BIT        = 3;
	localparam int STANDBY_KIND_BIT   = 2;
	localparam int ENTER_STANDBY_BIT  = 1;
	localparam int WD_KICK_BIT        = 0;

	// driver_and_glass_control fields
	localparam int GLASS_FAST_DIS_BIT = 14;
	localparam int GLASS_VOLT_LS_BIT  = 13;
	localparam int HS_NINE_BIT        = 12;
	localparam int HS_EIGHT_HI_BIT    = 11;
	localparam int HS_EIGHT_LO_BIT    = 10;
	localparam int HS_SEVEN_BIT       = 9;
	localparam int HS_SIX_BIT         = 8;
	localparam int GLASS_NEG_DIS_BIT  = 7;
	localparam int GLASS_REF_LSB      = 1;
	localparam int GLASS_REF_MSB      = 6;
	localparam int GLASS_ENABLE_BIT   = 0;

	// standby kinds
	localparam logic STANDBY_BATTERY   = 1'b0;
	localparam logic STANDBY_REGULATOR = 1'b1;

	// supply reset thresholds in millivolts
	localparam logic [12:0] RESET_THR_HIGH_MV = 13'h125C; // 4700 mV
	localparam logic [12:0] RESET_THR_LOW_MV  = 13'h0DAC; // 3500 mV

	// glass reference scaling in millivolts
	localparam logic [16:0] GLASS_FS_LOW_MV   = 17'h0_04B0; // 1200 mV
	localparam logic [16:0] GLASS_FS_HIGH_MV  = 17'h0_05DC; // 1500 mV
	localparam logic [16:0] GLASS_CODE_MAX    = 17'h0_003F; // 63

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [5:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	// enable bits held in the neighbouring control registers
	typedef struct packed {
		logic [4:0] bridge_pwm_en;
		logic       high_side_nine_pwm_gate;
		logic       high_side_eight_pwm_gate;
		logic       high_side_seven_pwm_gate;
		logic       high_side_six_pwm_gate;
		logic       glass_volt_pwm_gate;
		logic       glass_full_scale_sel;
	} drive_cfg_t;

	typedef struct packed {
		logic [4:0]  bridge_high;
		logic [4:0]  bridge_low;
		logic [4:0]  bridge_high_z;
		logic        high_side_nine;
		logic        high_side_eight_hi_cur;
		logic        high_side_eight_lo_cur;
		logic        high_side_seven;
		logic        high_side_six;
		logic        glass_fast_discharge_low;
		logic        glass_volt_low_side;
		logic        glass_negative_discharge;
		logic        glass_control_enable;
		logic [5:0]  glass_ref_code;
		logic [10:0] glass_ref_mv;
	} drive_out_t;

	// driver is on while its bit is set, and gated by pwm when its gate is enabled
	function automatic logic pwm_gate(input logic on, input logic gate_en, input logic pwm);
		return on & (~gate_en | pwm);
	endfunction : pwm_gate

endpackage : mirror_ctrl_pkg

`default_nettype wire

// [logic/bridge_gate.sv]
// one half bridge: turns the two control bits into driver enables.
// assumes the pwm input is synchronous to the register clock.
`timescale 1ns/1ns
`default_nettype none

module bridge_gate
	import mirror_ctrl_pkg::*;
(
	input  wire logic high_bit_i,
	input  wire logic low_bit_i,
	input  wire logic pwm_en_i,
	input  wire logic pwm_i,
	output var  logic high_on_o,
	output var  logic low_on_o,
	output var  logic high_z_o
);

	// both bits set is a shoot-through request: refuse it and float the output
	always_comb
	begin
		high_on_o = pwm_gate(high_bit_i & ~low_bit_i, pwm_en_i, pwm_i);
		low_on_o  = pwm_gate(low_bit_i & ~high_bit_i, pwm_en_i, pwm_i);
		high_z_o  = ~high_on_o & ~low_on_o;
	end

endmodule : bridge_gate

`default_nettype wire

// [logic/glass_ref_scale.sv]
// glass reference: scales the six-bit code onto the selected full-scale voltage.
// assumes the full-scale select comes from the neighbouring control register.
`timescale 1ns/1ns
`default_nettype none

module glass_ref_scale
	import mirror_ctrl_pkg::*;
(
	input  wire logic        [5:0]  code_i,
	input  wire logic               full_scale_sel_i,
	output var  logic        [10:0] ref_mv_o
);

	logic [16:0] full_scale;
	logic [16:0] product;

	// all-zero code gives zero volts; the top code gives full scale
	always_comb
	begin
		full_scale = full_scale_sel_i ? GLASS_FS_HIGH_MV : GLASS_FS_LOW_MV;
		product    = 17'(code_i) * full_scale;
		ref_mv_o   = 11'(product / GLASS_CODE_MAX);
	end

endmodule : glass_ref_scale

`default_nettype wire

// [logic/mirror_driver_control_regs.sv]
// control registers one and two of the mirror driver: storage, readback and driver decode.
// assumes the serial frame layer hands over decoded reads and writes, one per cycle,
// and that pwm, receive data and status inputs are synchronous to ref_clk_i.
//
// Operation
// - each of ten half-bridge bits switches its driver on when set
// - with pwm enable set, a bridge driver is on only while pwm is high
// - both bits of one half bridge set turns both off, output floats
// - interrupt enable bit lets the receive pin also carry the low interrupt
// - reset level bit picks a 4.7 V or 3.5 V supply reset threshold
// - in regulator standby, compare bit picks conditional or unconditional watchdog off
// - standby kind bit acts only at a write that also sets enter-standby, and always reads zero
// - writing the enter-standby bit starts standby; it never holds, reads zero
// - top bit of register two is written zero and always reads zero
// - glass fast-discharge bit switches the fast-discharge low side
// - glass low-side bit switches its driver, gated by pwm a when enabled
// - ninth high side follows its bit, gated by pwm a when enabled
// - eighth high side field: 10 high current, 01 low current, else off
// - seventh high side follows its bit, gated by pwm a when enabled, forced on by glass control
// - sixth high side follows its bit, gated by pwm b when enabled
// - glass negative-discharge bit switches the negative discharge path
// - six reference bits scale onto full scale; all zeros means zero volts
// - glass control enable bit turns regulation on and holds seventh output on
// - full-scale select picks 1.2 V or 1.5 V reference full scale
`timescale 1ns/1ns
`default_nettype none

module mirror_driver_control_regs
	import mirror_ctrl_pkg::*;
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    arst_n_i,
	input  wire mirror_ctrl_pkg::reg_req_t   reg_req_i,
	output var  logic            [15:0]  reg_rdata_o,
	output var  logic                    reg_hit_o,
	input  wire mirror_ctrl_pkg::drive_cfg_t drive_cfg_i,
	input  wire logic                    pwm_input_a_i,
	input  wire logic                    pwm_input_b_i,
	input  wire logic                    pwm_input_c_i,
	input  wire logic                    rx_data_i,
	input  wire logic                    irq_request_i,
	input  wire logic                    standby_active_i,
	input  wire logic                    supply_current_below_i,
	input  wire logic                    cfg_kick_toggle_i,
	output var  mirror_ctrl_pkg::drive_out_t drive_o,
	output var  logic                    rx_pin_o,
	output var  logic                    supply_reset_level_sel_o,
	output var  logic            [12:0]  supply_reset_threshold_mv_o,
	output var  logic                    enter_standby_o,
	output var  logic                    standby_kind_select_o,
	output var  logic                    watchdog_disable_o,
	output var  logic                    watchdog_service_o
);

	import mirror_ctrl_pkg::*;

	typedef struct packed {
		logic [15:0] bridge_mode;
		logic [15:0] driver_glass;
		logic [15:0] rdata;
		logic        hit;
		logic        standby_kind;
		logic        enter_standby;
		logic        wd_service;
		logic        wd_disable;
		logic        rx_pin;
		logic        reset_level;
		logic [12:0] reset_thr_mv;
		drive_out_t  drv;
	} state_t;

	state_t state_q;
	state_t state_d;

	localparam state_t STATE_RESET = '{
		bridge_mode:   BRIDGE_MODE_RESET,
		driver_glass:  DRIVER_GLASS_RESET,
		rdata:         16'h0000,
		hit:           1'b0,
		standby_kind:  STANDBY_BATTERY,
		enter_standby: 1'b0,
		wd_service:    1'b0,
		wd_disable:    1'b0,
		rx_pin:        1'b1,
		reset_level:   BRIDGE_MODE_RESET[RESET_LEVEL_BIT],
		reset_thr_mv:  RESET_THR_HIGH_MV,
		drv:           '0
	};

	// combinational decode of the half bridges and the glass reference
	logic [4:0]  br_high;
	logic [4:0]  br_low;
	logic [4:0]  br_z;
	logic [10:0] glass_mv;
	logic [15:0] bm_next;
	logic [15:0] dg_next;

	// each half bridge takes a high/low pair starting at the bridge field
	for (genvar b = 0; b < 5; b++)
	begin : g_bridge
		bridge_gate u_bridge_gate (
			.high_bit_i (bm_next[BRIDGE_FIELD_LSB + 2*b + 1]),
			.low_bit_i  (bm_next[BRIDGE_FIELD_LSB + 2*b]),
			.pwm_en_i   (drive_cfg_i.bridge_pwm_en[b]),
			.pwm_i      (pwm_input_a_i),
			.high_on_o  (br_high[b]),
			.low_on_o   (br_low[b]),
			.high_z_o   (br_z[b])
		);
	end

	glass_ref_scale u_glass_ref_scale (
		.code_i           (dg_next[GLASS_REF_MSB:GLASS_REF_LSB]),
		.full_scale_sel_i (drive_cfg_i.glass_full_scale_sel),
		.ref_mv_o         (glass_mv)
	);

	logic wr_bm;
	logic wr_dg;

	// address decode for the two registers
	always_comb
	begin
		wr_bm   = reg_req_i.wr && (reg_req_i.addr == BRIDGE_MODE_ADDR);
		wr_dg   = reg_req_i.wr && (reg_req_i.addr == DRIVER_GLASS_ADDR);
		// one-shot bits are masked off so they never store and always read zero
		bm_next = wr_bm ? (reg_req_i.wdata & BRIDGE_MODE_WMASK) : state_q.bridge_mode;
		dg_next = wr_dg ? (reg_req_i.wdata & DRIVER_GLASS_WMASK) : state_q.driver_glass;
	end

	// next state: storage, one-shot actions, readback and the driver outputs
	always_comb
	begin
		logic glass_on;
		logic gs_kick;
		glass_on = dg_next[GLASS_ENABLE_BIT];
		gs_kick  = 1'b0;

		state_d              = state_q;
		state_d.bridge_mode  = bm_next;
		state_d.driver_glass = dg_next;

		// standby request: kind is taken from the same write, only while it lands
		state_d.enter_standby = wr_bm && reg_req_i.wdata[ENTER_STANDBY_BIT];
		if (wr_bm && reg_req_i.wdata[ENTER_STANDBY_BIT])
		begin
			state_d.standby_kind = reg_req_i.wdata[STANDBY_KIND_BIT];
		end

		// a changed kick value is a service; config bit toggles are the alternative
		if (wr_bm && (reg_req_i.wdata[WD_KICK_BIT] != state_q.bridge_mode[WD_KICK_BIT]))
		begin
			gs_kick = 1'b1;
		end
		state_d.wd_service = gs_kick | cfg_kick_toggle_i;

		// watchdog off in regulator standby: always, or only at low supply current
		state_d.wd_disable = standby_active_i
			&& (state_q.standby_kind == STANDBY_REGULATOR)
			&& (bm_next[CUR_CMP_BIT] || supply_current_below_i);

		// receive pin pulls low for an interrupt only when sharing is enabled;
		// the interrupt wins over data, so software must not enable it mid-frame
		state_d.rx_pin = (bm_next[IRQ_RX_EN_BIT] && irq_request_i) ? 1'b0 : rx_data_i;

		state_d.reset_level  = bm_next[RESET_LEVEL_BIT];
		state_d.reset_thr_mv = bm_next[RESET_LEVEL_BIT] ? RESET_THR_LOW_MV
			: RESET_THR_HIGH_MV;

		// readback answers one cycle after the read; unmapped reads give zero
		if (reg_req_i.rd)
		begin
			case (reg_req_i.addr)
				BRIDGE_MODE_ADDR:
				begin
					state_d.rdata = state_q.bridge_mode & BRIDGE_MODE_WMASK;
					state_d.hit   = 1'b1;
				end
				DRIVER_GLASS_ADDR:
				begin
					state_d.rdata = state_q.driver_glass & DRIVER_GLASS_WMASK;
					state_d.hit   = 1'b1;
				end
				default:
				begin
					state_d.rdata = 16'h0000;
					state_d.hit   = 1'b0;
				end
			endcase
		end
		else
		begin
			state_d.hit = reg_req_i.wr && (wr_bm || wr_dg);
		end

		// half bridges
		state_d.drv.bridge_high   = br_high;
		state_d.drv.bridge_low    = br_low;
		state_d.drv.bridge_high_z = br_z;

		// single drivers of register two
		state_d.drv.glass_fast_discharge_low = dg_next[GLASS_FAST_DIS_BIT];
		state_d.drv.glass_volt_low_side = pwm_gate(dg_next[GLASS_VOLT_LS_BIT],
			drive_cfg_i.glass_volt_pwm_gate, pwm_input_a_i);
		state_d.drv.high_side_nine = pwm_gate(dg_next[HS_NINE_BIT],
			drive_cfg_i.high_side_nine_pwm_gate, pwm_input_a_i);
		state_d.drv.high_side_eight_hi_cur = pwm_gate(
			dg_next[HS_EIGHT_HI_BIT] & ~dg_next[HS_EIGHT_LO_BIT],
			drive_cfg_i.high_side_eight_pwm_gate, pwm_input_c_i);
		state_d.drv.high_side_eight_lo_cur = pwm_gate(
			dg_next[HS_EIGHT_LO_BIT] & ~dg_next[HS_EIGHT_HI_BIT],
			drive_cfg_i.high_side_eight_pwm_gate, pwm_input_c_i);
		// glass regulation needs the seventh output as its supply, so it is forced on
		state_d.drv.high_side_seven = glass_on ? 1'b1 : pwm_gate(dg_next[HS_SEVEN_BIT],
			drive_cfg_i.high_side_seven_pwm_gate, pwm_input_a_i);
		state_d.drv.high_side_six = pwm_gate(dg_next[HS_SIX_BIT],
			drive_cfg_i.high_side_six_pwm_gate, pwm_input_b_i);
		state_d.drv.glass_negative_discharge = dg_next[GLASS_NEG_DIS_BIT];
		state_d.drv.glass_control_enable = glass_on;
		state_d.drv.glass_ref_code = dg_next[GLASS_REF_MSB:GLASS_REF_LSB];
		state_d.drv.glass_ref_mv   = glass_mv;
	end

	// the whole state in one register, reset to the documented values
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q <= STATE_RESET;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// outputs straight from the state register
	always_comb
	begin
		reg_rdata_o                 = state_q.rdata;
		reg_hit_o                   = state_q.hit;
		drive_o                     = state_q.drv;
		rx_pin_o                    = state_q.rx_pin;
		supply_reset_level_sel_o    = state_q.reset_level;
		supply_reset_threshold_mv_o = state_q.reset_thr_mv;
		enter_standby_o             = state_q.enter_standby;
		standby_kind_select_o       = state_q.standby_kind;
		watchdog_disable_o          = state_q.wd_disable;
		watchdog_service_o          = state_q.wd_service;
	end

endmodule : mirror_driver_control_regs

`default_nettype wire
